// ===== verilog/vr_seq_pkg.sv
// constants, types and decoders shared by both ends of the regulator link
// assumes a single 125 MHz clock on both ends and synchronous pin inputs
package vr_seq_pkg;

  // ==========================================================
  // clock and times
  localparam int CLK_MHZ        = 125;
  localparam int PG_DELAY_NS    = 20000;
  localparam int SLEW_STEP_NS   = 12500;    // one 12.5mV code at 1mV/us
  localparam int HOST_SETUP_NS  = 10000;
  localparam int RESET_WAIT_NS  = 1000000;
  localparam int BIT_HALF_CYC   = 8;
  // least times, rounded up to whole cycles
  localparam int PG_DELAY_CYC   = (PG_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int SLEW_CYC       = (SLEW_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOST_SETUP_CYC = (HOST_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_WAIT_CYC = (RESET_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W          = 17;

  // ==========================================================
  // voltage codes and serial frame layout
  localparam int        VID_W      = 7;
  localparam int        RAILS      = 3;
  localparam logic [6:0] VID_OFF   = 7'h7c;  // codes from here up are off
  localparam logic [6:0] BOOT_VID0 = 7'h10;  // plain defaults
  localparam logic [6:0] BOOT_VID1 = 7'h1c;
  localparam logic [6:0] BOOT_VID2 = 7'h28;
  localparam logic [6:0] BOOT_VID3 = 7'h70;
  localparam int        FRAME_BITS = 10;
  localparam int        FR_SEL_HI  = 9;
  localparam int        FR_SEL_LO  = 8;
  localparam int        FR_PSL     = 7;
  localparam logic [1:0] SEL_ALL   = 2'h3;

  // ==========================================================
  // state enumerations
  typedef enum logic [2:0] {
    DS_OFF, DS_WAIT_REF, DS_SOFT, DS_BOOT, DS_SERIAL, DS_FAULT
  } dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE, HS_SETUP, HS_WAIT_PG, HS_WAIT_SYS, HS_HOLD, HS_RUN,
    HS_SEND, HS_DROPPED
  } host_state_t;

  // ==========================================================
  // decoders
  function automatic logic vid_is_off(input logic [6:0] v);
    vid_is_off = (v >= VID_OFF);
  endfunction : vid_is_off

  function automatic logic [6:0] boot_vid(input logic [1:0] c);
    case (c)
      2'h0:    boot_vid = BOOT_VID0;
      2'h1:    boot_vid = BOOT_VID1;
      2'h2:    boot_vid = BOOT_VID2;
      default: boot_vid = BOOT_VID3;
    endcase
  endfunction : boot_vid

endpackage : vr_seq_pkg

// ===== verilog/vr_link_if.sv
// pins between the regulator sequencer and the host/chipset
// assumes an external pull-up on the open-drain power good line
interface vr_link_if;

  // ==========================================================
  // host driven pins
  logic shutdown_n;
  logic serial_vid_clock;
  logic serial_vid_data;
  logic system_power_ok_in;
  logic strap_sense_pin_a;
  logic strap_sense_pin_b;
  // open-drain power good, drive value and enable
  logic pg_o;
  logic pg_oe;
  logic power_good_out;

  // pull-up wins when the device releases the line
  assign power_good_out = pg_oe ? pg_o : 1'b1;

  modport device (
    input  shutdown_n,
    input  serial_vid_clock,
    input  serial_vid_data,
    input  system_power_ok_in,
    input  strap_sense_pin_a,
    input  strap_sense_pin_b,
    output pg_o,
    output pg_oe
  );

  modport host (
    output shutdown_n,
    output serial_vid_clock,
    output serial_vid_data,
    output system_power_ok_in,
    output strap_sense_pin_a,
    output strap_sense_pin_b,
    input  power_good_out
  );

endinterface : vr_link_if

// ===== verilog/vr_delay_timer.sv
// saturating cycle counter used for every fixed delay
// assumes run is a level; dropping it clears the count
module vr_delay_timer #(
  parameter int unsigned LIMIT = 1
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // control
  input  wire logic run,
  output      logic done
);
  import vr_seq_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } tmr_t;

  tmr_t r_q;
  tmr_t r_d;

  // count while run holds, stop at the limit
  always_comb
  begin
    r_d = r_q;
    if (!run)
      r_d.cnt = '0;
    else if (r_q.cnt != CNT_W'(LIMIT))
      r_d.cnt = r_q.cnt + CNT_W'(1);
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign done = (r_q.cnt == CNT_W'(LIMIT));

endmodule : vr_delay_timer

// ===== verilog/vr_sequencer.sv
// startup sequencer and power good supervisor, regulator end
// assumes analog comparator results arrive as synchronous levels
module vr_sequencer (
  // clock and power-on reset
  input  wire logic                             mclk,
  input  wire logic                             rst_n,
  // link to host
  vr_link_if.device                             link,
  // analog status
  input  wire logic                             supply_valid,
  input  wire logic                             reference_ok,
  input  wire logic                             battery_present,
  input  wire logic [vr_seq_pkg::RAILS-1:0]     in_regulation,
  input  wire logic [vr_seq_pkg::RAILS-1:0]     window_over,
  input  wire logic [vr_seq_pkg::RAILS-1:0]     window_under,
  // power stage control
  output      logic [vr_seq_pkg::RAILS-1:0]     gate_enable,
  output      logic [vr_seq_pkg::RAILS-1:0]     skip_mode,
  output      logic                             discharge_en,
  output      logic                             fault_latched,
  output      logic                             combined_mode,
  output      logic [vr_seq_pkg::RAILS*7-1:0]   target_vid
);
  import vr_seq_pkg::*;

  typedef struct packed {
    dev_state_t              state;
    logic [RAILS-1:0][6:0]   target;
    logic [RAILS-1:0][6:0]   goal;
    logic [RAILS-1:0]        down;
    logic [1:0]              boot;
    logic                    boot_stored;
    logic                    combined;
    logic                    psl;
    logic                    hold;
    logic                    blank;
    logic                    pg_low;
    logic [FRAME_BITS-1:0]   shift;
    logic [3:0]              nbits;
    logic                    clk_prev;
    logic                    pok_prev;
  } dev_t;

  dev_t r_q;
  dev_t r_d;

  logic slew_tick;
  logic hold_done;
  logic blank_done;
  logic running;
  logic slewing;
  logic all_ok;
  logic all_off;
  logic any_fault;

  // ==========================================================
  // delay counters
  vr_delay_timer #(.LIMIT(SLEW_CYC - 1)) u_slew (
    .mclk (mclk),
    .rst_n(rst_n),
    .run  (!slew_tick),
    .done (slew_tick)
  );

  vr_delay_timer #(.LIMIT(PG_DELAY_CYC)) u_hold (
    .mclk (mclk),
    .rst_n(rst_n),
    .run  (r_q.hold && all_ok && !slewing && running),
    .done (hold_done)
  );

  vr_delay_timer #(.LIMIT(PG_DELAY_CYC)) u_blank (
    .mclk (mclk),
    .rst_n(rst_n),
    .run  (r_q.blank && !slewing),
    .done (blank_done)
  );

  // ==========================================================
  // per-rail status
  always_comb
  begin
    slewing   = 1'b0;
    all_ok    = 1'b1;
    all_off   = 1'b1;
    any_fault = 1'b0;
    for (int i = 0; i < RAILS; i++)
    begin
      if (r_q.target[i] != r_q.goal[i])
        slewing = 1'b1;
      if (!vid_is_off(r_q.target[i]))
      begin
        all_off = 1'b0;
        if (!in_regulation[i])
          all_ok = 1'b0;
        if (window_under[i] || (window_over[i] && !r_q.down[i]))
          any_fault = 1'b1;
      end
    end
  end

  assign running = (r_q.state == DS_SOFT) || (r_q.state == DS_BOOT) ||
                   (r_q.state == DS_SERIAL);

  // ==========================================================
  // sequencing, slewing, serial frames and power good
  always_comb
  begin
    r_d          = r_q;
    r_d.clk_prev = link.serial_vid_clock;
    r_d.pok_prev = link.system_power_ok_in;
    case (r_q.state)
      DS_OFF:
      begin
        r_d.hold = 1'b1;
        r_d.blank = 1'b0;
        for (int i = 0; i < RAILS; i++)
        begin
          r_d.target[i] = VID_OFF;
          r_d.goal[i]   = VID_OFF;
        end
        r_d.down = '0;
        if (supply_valid && link.shutdown_n)
          r_d.state = DS_WAIT_REF;
      end
      DS_WAIT_REF:
        if (reference_ok)
        begin
          r_d.combined = link.strap_sense_pin_a || link.strap_sense_pin_b;
          for (int i = 0; i < RAILS; i++)
            r_d.goal[i] = boot_vid({link.serial_vid_clock,
                                    link.serial_vid_data});
          r_d.state = DS_SOFT;
        end
      DS_SOFT:
        if (!battery_present)
          r_d.state = DS_FAULT;
        else if (!slewing && all_ok)
          r_d.state = DS_BOOT;
      DS_BOOT:
      begin
        if (hold_done && !r_q.boot_stored)
        begin
          r_d.boot        = {link.serial_vid_clock, link.serial_vid_data};
          r_d.boot_stored = 1'b1;
        end
        if (link.system_power_ok_in && !r_q.hold && !slewing)
        begin
          r_d.state = DS_SERIAL;
          r_d.nbits = '0;
        end
      end
      DS_SERIAL:
        if (!link.system_power_ok_in && r_q.pok_prev)
        begin
          r_d.hold  = 1'b1;
          r_d.state = DS_BOOT;
          for (int i = 0; i < RAILS; i++)
          begin
            r_d.goal[i] = boot_vid(r_q.boot);
            r_d.down[i] = r_q.down[i] || (boot_vid(r_q.boot) > r_q.target[i]);
          end
        end
        else if (link.system_power_ok_in && link.serial_vid_clock &&
                 !r_q.clk_prev)
        begin
          r_d.shift = {r_q.shift[FRAME_BITS-2:0], link.serial_vid_data};
          r_d.nbits = r_q.nbits + 4'h1;
          if (r_q.nbits == 4'(FRAME_BITS - 1))
          begin
            r_d.nbits = '0;
            r_d.psl   = r_d.shift[FR_PSL];
            for (int i = 0; i < RAILS; i++)
              if (r_d.shift[FR_SEL_HI:FR_SEL_LO] == SEL_ALL ||
                  r_d.shift[FR_SEL_HI:FR_SEL_LO] == 2'(i) ||
                  (r_q.combined && i < 2 &&
                   r_d.shift[FR_SEL_HI:FR_SEL_LO] < 2'h2))
              begin
                r_d.goal[i] = r_d.shift[6:0];
                if (r_d.shift[6:0] > r_q.target[i])
                  r_d.down[i] = 1'b1;
              end
          end
        end
      DS_FAULT:
        r_d.hold = 1'b1;
      default:
        r_d.state = DS_OFF;
    endcase

    // one code step per slew period toward each goal
    if (slew_tick && running)
      for (int i = 0; i < RAILS; i++)
        if (r_q.target[i] < r_q.goal[i])
          r_d.target[i] = r_q.target[i] + 7'h01;
        else if (r_q.target[i] > r_q.goal[i])
          r_d.target[i] = r_q.target[i] - 7'h01;

    // upper threshold comes back once the rail settles; a new goal wins
    for (int i = 0; i < RAILS; i++)
      if (in_regulation[i] && r_q.target[i] == r_d.goal[i])
        r_d.down[i] = 1'b0;

    // hold low until 20us in regulation, blank 20us past slewing
    if (hold_done)
      r_d.hold = 1'b0;
    if (slewing && r_q.state == DS_SERIAL)
      r_d.blank = 1'b1;
    else if (blank_done)
      r_d.blank = 1'b0;

    // enable low clears the latch; lost supply latches off
    if (!link.shutdown_n)
      r_d.state = DS_OFF;
    else if (!supply_valid && r_q.state != DS_OFF)
      r_d.state = DS_FAULT;

    r_d.pg_low = !running || r_d.hold || all_off ||
                 (any_fault && !slewing && !r_q.blank);
  end

  // state register; power-on reset starts clean
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q       <= '0;
      r_q.state <= DS_OFF;
      r_q.hold  <= 1'b1;
      r_q.pg_low <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  // ==========================================================
  // outputs
  assign link.pg_o  = 1'b0;
  assign link.pg_oe = r_q.pg_low || !link.shutdown_n;
  assign fault_latched = (r_q.state == DS_FAULT);
  assign discharge_en  = (r_q.state == DS_FAULT) ||
                         (r_q.state == DS_OFF);
  assign combined_mode = r_q.combined;
  assign target_vid    = r_q.target;

  generate
    for (genvar g = 0; g < RAILS; g++)
    begin : g_rail
      // gates stop at once on lost supply
      assign gate_enable[g] = running && supply_valid &&
                              !vid_is_off(r_q.target[g]);
      assign skip_mode[g]   = (r_q.state != DS_SERIAL) || !r_q.psl;
    end
  endgenerate

endmodule : vr_sequencer

// ===== verilog/vr_host.sv
// host and chipset end: boot code, enable, power ok, serial codes
// assumes the device end sits on the same clock
module vr_host #(
  parameter int unsigned RESET_WAIT = vr_seq_pkg::RESET_WAIT_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // link to regulator
  vr_link_if.host         link,
  // user side
  input  wire logic       power_on,
  input  wire logic [1:0] boot_code,
  input  wire logic       strap_combined,
  input  wire logic       planes_ready,
  input  wire logic       pok_drop,
  input  wire logic       cmd_valid,
  output      logic       cmd_ready,
  input  wire logic [9:0] cmd_frame,
  output      logic       system_reset_n
);
  import vr_seq_pkg::*;

  typedef struct packed {
    host_state_t           state;
    logic                  enable;
    logic                  pok;
    logic                  rstn;
    logic                  bit_clk;
    logic [FRAME_BITS-1:0] shift;
    logic [3:0]            nbits;
  } host_t;

  host_t r_q;
  host_t r_d;
  logic  setup_done;
  logic  wait_done;
  logic  bit_tick;
  logic  boot_drive;

  // ==========================================================
  // delay counters
  vr_delay_timer #(.LIMIT(HOST_SETUP_CYC)) u_setup (
    .mclk (mclk),
    .rst_n(rst_n),
    .run  (r_q.state == HS_SETUP || r_q.state == HS_HOLD),
    .done (setup_done)
  );

  vr_delay_timer #(.LIMIT(RESET_WAIT)) u_wait (
    .mclk (mclk),
    .rst_n(rst_n),
    .run  (r_q.state == HS_HOLD),
    .done (wait_done)
  );

  vr_delay_timer #(.LIMIT(BIT_HALF_CYC - 1)) u_bit (
    .mclk (mclk),
    .rst_n(rst_n),
    .run  (r_q.state == HS_SEND && !bit_tick),
    .done (bit_tick)
  );

  // ==========================================================
  // power-up order and frame shifting
  always_comb
  begin
    r_d = r_q;
    case (r_q.state)
      HS_IDLE:
        if (power_on)
          r_d.state = HS_SETUP;
      HS_SETUP:
        if (setup_done)
        begin
          r_d.enable = 1'b1;
          r_d.state = HS_WAIT_PG;
        end
      HS_WAIT_PG:
        if (link.power_good_out)
          r_d.state = HS_WAIT_SYS;
      HS_WAIT_SYS:
        if (link.power_good_out && planes_ready)
        begin
          r_d.pok   = 1'b1;
          r_d.state = HS_HOLD;
        end
      HS_HOLD:
        // boot code also stays up for the setup time after power ok
        if (wait_done && setup_done)
        begin
          r_d.rstn  = 1'b1;
          r_d.state = HS_RUN;
        end
      HS_RUN:
        if (pok_drop)
        begin
          r_d.pok   = 1'b0;
          r_d.state = HS_DROPPED;
        end
        else if (cmd_valid)
        begin
          r_d.shift = cmd_frame;
          r_d.nbits = 4'(FRAME_BITS);
          r_d.state = HS_SEND;
        end
      HS_SEND:
        if (bit_tick)
        begin
          if (r_q.bit_clk)
          begin
            r_d.bit_clk = 1'b0;
            r_d.shift = {r_q.shift[FRAME_BITS-2:0], 1'b0};
            r_d.nbits = r_q.nbits - 4'h1;
          end
          else if (r_q.nbits != 4'h0)
            r_d.bit_clk = 1'b1;
          else
            r_d.state = HS_RUN;
        end
      HS_DROPPED:
        if (!pok_drop)
          r_d.state = HS_WAIT_SYS;
      default:
        r_d.state = HS_IDLE;
    endcase
    if (!power_on)
    begin
      r_d.state = HS_IDLE;
      r_d.enable  = 1'b0;
      r_d.pok     = 1'b0;
      r_d.rstn    = 1'b0;
      r_d.bit_clk = 1'b0;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q       <= '0;
      r_q.state <= HS_IDLE;
    end
    else
      r_q <= r_d;
  end

  // ==========================================================
  // outputs; boot code stands on the serial pins outside run and send
  assign boot_drive = (r_q.state != HS_RUN) && (r_q.state != HS_SEND);
  assign link.serial_vid_clock   = boot_drive ? boot_code[1] : r_q.bit_clk;
  assign link.serial_vid_data    = boot_drive ? boot_code[0] :
                                   (r_q.state == HS_SEND) &&
                                   r_q.shift[FRAME_BITS-1];
  assign link.shutdown_n         = r_q.enable;
  assign link.system_power_ok_in = r_q.pok;
  assign link.strap_sense_pin_a  = strap_combined;
  assign link.strap_sense_pin_b  = 1'b0;
  assign cmd_ready               = (r_q.state == HS_RUN) && !pok_drop;
  assign system_reset_n          = r_q.rstn;

endmodule : vr_host

// ===== testbench/vr_seq_props.sv
// assertions on the pins between host end and regulator end
// assumes the bench wires these inputs to the link interface
module vr_seq_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link pins
  input wire logic shutdown_n,
  input wire logic serial_vid_clock,
  input wire logic serial_vid_data,
  input wire logic system_power_ok_in,
  input wire logic pg_o,
  input wire logic pg_oe,
  input wire logic power_good_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import vr_seq_pkg::*;

  // ==========================================================
  // helper counters
  logic [CNT_W-1:0] low_q, boot_q, pok_q;
  logic [1:0]       pins_q;

  // low time of power good, stable time of pins, power ok time
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      {low_q, boot_q, pok_q} <= '0;
      pins_q <= '0;
    end
    else
    begin
      pins_q <= {serial_vid_clock, serial_vid_data};
      low_q  <= !pg_oe ? '0 : (&low_q ? low_q : low_q + 1'b1);
      pok_q  <= !system_power_ok_in ? '0 : (&pok_q ? pok_q : pok_q + 1'b1);
      if (pins_q != {serial_vid_clock, serial_vid_data})
        boot_q <= '0;
      else if (!(&boot_q))
        boot_q <= boot_q + 1'b1;
    end

  // ==========================================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_RESET_LOW: assert property
    ($rose(rst_n) |-> pg_oe)
    else $error("power good released right after reset");
  AST_DISABLE_LOW: assert property
    (!shutdown_n |-> pg_oe)
    else $error("power good released while disabled");
  AST_DISABLE_FALL: assert property
    ($fell(shutdown_n) |=> pg_oe [*8])
    else $error("power good not held low after disable");
  AST_DRIVE_LOW: assert property
    (pg_oe |-> !pg_o && !power_good_out)
    else $error("power good line not low while pulled");
  AST_POK_FALL: assert property
    ($fell(system_power_ok_in) && shutdown_n && !pg_oe |=> pg_oe [*8])
    else $error("power good not pulled on power ok fall");
  // window faults may clear at once; only releases with power ok low wait
  AST_MIN_LOW: assert property
    ($fell(pg_oe) && !system_power_ok_in |-> low_q >= PG_DELAY_CYC)
    else $error("power good released too early");
  AST_BOOT_SETUP: assert property
    ($rose(shutdown_n) |-> boot_q >= HOST_SETUP_CYC)
    else $error("boot code not set up before enable");
  AST_BOOT_HOLD: assert property
    (system_power_ok_in && pok_q < HOST_SETUP_CYC
     |-> $stable({serial_vid_clock, serial_vid_data}))
    else $error("boot code changed too soon after power ok");
  AST_POK_AFTER_PG: assert property
    ($rose(system_power_ok_in) |-> power_good_out)
    else $error("power ok raised before power good");

endmodule : vr_seq_props

// ===== testbench/vr_startup_powergood_sequencer_tb.sv
// bench joining host end and regulator end over the link
// assumes package constants; host reset wait shortened to 50 cycles
module vr_startup_powergood_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vr_seq_pkg::*;

  // ==========================================================
  // signals
  logic             mclk, rst_n, power_on, strap_combined, planes_ready;
  logic             pok_drop, cmd_valid, supply_valid, reference_ok;
  logic             battery_present, discharge_en, fault_latched;
  logic             combined_mode, cmd_ready, system_reset_n;
  logic             link_en, pg_line, pok;
  logic [1:0]       boot_code;
  logic [9:0]       cmd_frame;
  logic [RAILS-1:0] in_regulation, window_over, window_under;
  logic [RAILS-1:0] gate_enable, skip_mode;
  logic [20:0]      target_vid;
  int               err_count, n_checks, n, bad;

  // ==========================================================
  // ends, link and checker
  vr_link_if vr_link_if_i ();
  assign link_en = vr_link_if_i.shutdown_n;
  assign pg_line = vr_link_if_i.power_good_out;
  assign pok     = vr_link_if_i.system_power_ok_in;

  vr_sequencer vr_sequencer_i (.mclk(mclk), .rst_n(rst_n),
    .link(vr_link_if_i), .supply_valid(supply_valid),
    .reference_ok(reference_ok), .battery_present(battery_present),
    .in_regulation(in_regulation), .window_over(window_over),
    .window_under(window_under), .gate_enable(gate_enable),
    .skip_mode(skip_mode), .discharge_en(discharge_en),
    .fault_latched(fault_latched), .combined_mode(combined_mode),
    .target_vid(target_vid));

  vr_host #(.RESET_WAIT(50)) vr_host_i (.mclk(mclk), .rst_n(rst_n),
    .link(vr_link_if_i), .power_on(power_on), .boot_code(boot_code),
    .strap_combined(strap_combined), .planes_ready(planes_ready),
    .pok_drop(pok_drop), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_frame(cmd_frame), .system_reset_n(system_reset_n));

  vr_seq_props vr_seq_props_i (.mclk(mclk), .rst_n(rst_n),
    .shutdown_n(vr_link_if_i.shutdown_n),
    .serial_vid_clock(vr_link_if_i.serial_vid_clock),
    .serial_vid_data(vr_link_if_i.serial_vid_data),
    .system_power_ok_in(vr_link_if_i.system_power_ok_in),
    .pg_o(vr_link_if_i.pg_o), .pg_oe(vr_link_if_i.pg_oe),
    .power_good_out(vr_link_if_i.power_good_out));

  // 125 MHz clock
  always #4 mclk = ~mclk;

  // ==========================================================
  // helpers
  task automatic tick(input int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic lost(input string what, input int lim);
    if (n >= lim)
    begin
      err_count++;
      $display("Error %s expected event seen timeout", what);
      print_verdict();
    end
  endtask : lost

  task automatic wait_en(input logic lvl);
    for (n = 0; n < 1400 && link_en !== lvl; n++) tick();
    lost("enable", 1400);
  endtask : wait_en

  // ==========================================================
  // scenarios
  // supply low: enable seen, nothing switches
  task automatic t_lockout();
    chk("reset", 6'h04,
        {gate_enable, discharge_en, fault_latched, pg_line});
    power_on = 1'b1;
    wait_en(1'b1);
    tick(20);
    chk("lockout", 6'h04,
        {gate_enable, discharge_en, fault_latched, pg_line});
    $display("test lockout done");
  endtask : t_lockout

  // soft-start without battery latches a fault, disable clears it
  task automatic t_battery();
    {supply_valid, reference_ok} = 2'h3;
    for (n = 0; n < 20 && fault_latched !== 1'b1; n++) tick();
    chk("fault", 6'h06,
        {gate_enable, discharge_en, fault_latched, pg_line});
    power_on = 1'b0;
    tick(3);
    chk("cleared", 2'h2, {discharge_en, fault_latched});
    battery_present = 1'b1;
    $display("test battery done");
  endtask : t_battery

  // soft-start skips pulses, supply loss drops gates at once
  task automatic t_supply_drop();
    power_on = 1'b1;
    wait_en(1'b1);
    tick(1700);
    chk("soft", 6'h3f, {gate_enable, skip_mode});
    supply_valid = 1'b0;
    #1;
    chk("gates drop", 3'h0, gate_enable);
    tick();
    chk("latched off", 5'h03,
        {gate_enable, discharge_en, fault_latched});
    supply_valid = 1'b1;
    power_on = 1'b0;
    tick(3);
    chk("restart", 1'b0, fault_latched);
    $display("test lockout drop done");
  endtask : t_supply_drop

  // full ramp to boot code, release, power ok, reset wait
  task automatic t_startup();
    power_on = 1'b1;
    for (n = 0; n < 30000 && target_vid !== {3{7'h70}}; n++) tick();
    lost("ramp", 30000);
    for (n = 0; n < 3000 && pg_line !== 1'b1; n++) tick();
    chk("release", 1, n >= PG_DELAY_CYC && n < PG_DELAY_CYC + 10);
    chk("boot", 4'hf, {skip_mode, combined_mode});
    planes_ready = 1'b1;
    for (n = 0; n < 20 && pok !== 1'b1; n++) tick();
    lost("power ok", 20);
    for (n = 0; n < 1400 && system_reset_n !== 1'b1; n++) tick();
    chk("reset wait", 1, n >= 50 && n >= HOST_SETUP_CYC &&
        n < 1400);
    for (n = 0; n < 20 && cmd_ready !== 1'b1; n++) tick();
    lost("ready", 20);
    $display("test startup done");
  endtask : t_startup

  // set-voltage frame: both cores move, power good stays blanked
  task automatic t_serial();
    cmd_frame = {2'h0, 1'b1, 7'h6c};
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    bad = 0;
    for (n = 0; n < 11000 && target_vid !== {7'h70, 7'h6c, 7'h6c}; n++)
    begin
      tick();
      if (pg_line !== 1'b1) bad++;
    end
    lost("slew", 11000);
    // a rail fault inside the tail after slewing must stay masked
    window_under = 3'h1;
    repeat (2400)
    begin
      tick();
      if (pg_line !== 1'b1) bad++;
    end
    window_under = '0;
    chk("blanked", 0, bad);
    chk("modes", 3'h0, skip_mode);
    $display("test serial done");
  endtask : t_serial

  // an over and an under window excursion each pull power good low
  task automatic t_window();
    tick(200);
    for (int k = 0; k < 2; k++)
    begin
      {window_over, window_under} = k ? 6'h02 : 6'h20;
      tick(2);
      chk("excursion", 1'b0, pg_line);
      {window_over, window_under} = '0;
      for (n = 0; n < 3000 && pg_line !== 1'b1; n++) tick();
      lost("recover", 3000);
    end
    $display("test window done");
  endtask : t_window

  // power ok fall: low at once, back to the stored boot code
  task automatic t_pok();
    boot_code = 2'h0;
    pok_drop = 1'b1;
    for (n = 0; n < 20 && pok !== 1'b0; n++) tick();
    tick();
    chk("drop low", 1'b0, pg_line);
    for (n = 0; n < 11000 && target_vid !== {3{7'h70}}; n++) tick();
    lost("back to boot", 11000);
    for (n = 0; n < 3000 && pg_line !== 1'b1; n++) tick();
    chk("drop release", 1, n >= PG_DELAY_CYC && n < 3000);
    pok_drop = 1'b0;
    $display("test power ok drop done");
  endtask : t_pok

  // disable pulls power good low in the same cycle
  task automatic t_off();
    power_on = 1'b0;
    wait_en(1'b0);
    chk("off low", 1'b0, pg_line);
    tick();
    chk("off discharge", 1'b1, discharge_en);
    $display("test disable done");
  endtask : t_off

  // ==========================================================
  // main sequence
  initial
  begin
    {mclk, rst_n, power_on, planes_ready, pok_drop, cmd_valid} = '0;
    {supply_valid, reference_ok, battery_present} = '0;
    {window_over, window_under, cmd_frame} = '0;
    {boot_code, strap_combined, in_regulation} = 6'h3f;
    tick(3);
    rst_n = 1'b1;
    tick(2);
    t_lockout();
    t_battery();
    t_supply_drop();
    t_startup();
    t_serial();
    t_window();
    t_pok();
    t_off();
    print_verdict();
  end

endmodule : vr_startup_powergood_sequencer_tb
